// ---- rtl/irqpr_regs.v ----
// irqpr_regs.v: pending-request registers for port A/comparator and port C
// sources, and the group-0 enable/priority pair, behind an APB slave.
// assumes request pulses and ack come from logic on clk_sys.
//
// Functional notes
// - a port A or comparator request sets its group-1 pending bit
// - a port C request sets its group-2 pending bit
// - global enable and CTRL bit 0 on: pending group-1/2 requests go to cpu as vectors
// - group-1 bit 7 is pin 7, bit 6 is pin 6 or comparator
// - group-1 bits 5..0 are port A pins 5..0
// - group-2 bits 3..0 are port C pins 3..0
// - each group-0 source has a high and low enable bit, same position
// - pair: 00 off, low only level 1, high only level 2, both level 3
// - enable bit 6 timer1, 5 timer0, 4 rx, 3 tx, 0 converter
// - low enable bits 7 and 2..1 are read-only zero
// - cpu acknowledge or written zero clears a pending bit
// - written one raises a pending bit; acknowledge clears it
// - each request is a one-cycle pulse latched into its pending bit
`timescale 1ns/1ps
`default_nettype none
`include "irqpr_defines.vh"
module irqpr_regs
#(
    parameter G1_W = 8,
    parameter G2_W = 4
)
(
    input wire clk_sys,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [G1_W-1:0] porta_req,
    input wire [G2_W-1:0] portc_req,
    input wire global_interrupt_enable,
    input wire vec_ack,
    output reg vec_req_q,
    output reg [3:0] vec_src_q,
    output reg [1:0] vec_level_q,
    output wire [7:0] group0_level_timer1,
    output wire irq_out
);
    wire [13:0] widx;
    wire wr_en;
    wire rd_en;
    wire hit;
    wire [G1_W-1:0] g1_pend;
    wire [G2_W-1:0] g2_pend;
    wire [G1_W-1:0] g1_ack;
    wire [G2_W-1:0] g2_ack;
    wire wr_g1;
    wire wr_g2;
    reg [7:0] group0_enable_high_q;
    reg [7:0] group0_enable_low_q;
    reg [`IRQPR_ST_W-1:0] stat_q;
    reg [`IRQPR_ST_W-1:0] stat_d;
    reg [`IRQPR_ST_W-1:0] mask_q;
    reg vec_en_q;
    reg [31:0] rd_mux;
    reg found;
    reg [3:0] pick_src;
    integer i;

    assign widx = paddr[15:2];
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign hit = (widx == `IRQPR_IDX_G0_EN_HI) | (widx == `IRQPR_IDX_G0_EN_LO)
        | (widx == `IRQPR_IDX_G1_PEND) | (widx == `IRQPR_IDX_G2_PEND)
        | (widx == `IRQPR_IDX_IRQ_STAT) | (widx == `IRQPR_IDX_IRQ_MASK)
        | (widx == `IRQPR_IDX_CTRL) | (widx == `IRQPR_IDX_VECT);
    assign pslverr = psel & penable & ~hit;
    assign wr_g1 = wr_en & (widx == `IRQPR_IDX_G1_PEND);
    assign wr_g2 = wr_en & (widx == `IRQPR_IDX_G2_PEND);

    // pending flags, one per source
    genvar g;
    generate
        for (g = 0; g < G1_W; g = g + 1)
        begin : g1_bits
            assign g1_ack[g] = vec_ack & vec_req_q & ~vec_src_q[3]
                & (vec_src_q[2:0] == g);
            irqpr_pend_bit u_bit
            (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .hw_set(porta_req[g]),
                .sw_wr(wr_g1),
                .sw_val(pwdata[g]),
                .ack(g1_ack[g]),
                .pend_q(g1_pend[g])
            );
        end
        for (g = 0; g < G2_W; g = g + 1)
        begin : g2_bits
            assign g2_ack[g] = vec_ack & vec_req_q & vec_src_q[3]
                & (vec_src_q[2:0] == g);
            irqpr_pend_bit u_bit
            (
                .clk_sys(clk_sys),
                .rst_b(rst_b),
                .hw_set(portc_req[g]),
                .sw_wr(wr_g2), // upper bits simply do not exist
                .sw_val(pwdata[g]),
                .ack(g2_ack[g]),
                .pend_q(g2_pend[g])
            );
        end
    endgenerate

    // group-0 enable pair and control registers
    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            group0_enable_high_q <= `IRQPR_RST_BYTE;
            group0_enable_low_q <= `IRQPR_RST_BYTE;
            mask_q <= {`IRQPR_ST_W{1'b0}};
            vec_en_q <= 1'b0;
        end
        else if (wr_en)
        begin
            case (widx)
                `IRQPR_IDX_G0_EN_HI: group0_enable_high_q <= pwdata[7:0] & `IRQPR_G0_EN_WMASK;
                `IRQPR_IDX_G0_EN_LO: group0_enable_low_q <= pwdata[7:0] & `IRQPR_G0_EN_WMASK;
                `IRQPR_IDX_IRQ_MASK: mask_q <= pwdata[`IRQPR_ST_W-1:0];
                `IRQPR_IDX_CTRL: vec_en_q <= pwdata[0];
                default: vec_en_q <= vec_en_q;
            endcase
        end
    end

    // timer1 pair decoded as a level for the core's arbiter
    assign group0_level_timer1 = {6'h00,
        group0_enable_high_q[`IRQPR_BIT_TIMER1], group0_enable_low_q[`IRQPR_BIT_TIMER1]};

    // lowest numbered pending source in groups 1 then 2
    always @*
    begin
        found = 1'b0;
        pick_src = 4'h0;
        for (i = G1_W - 1; i >= 0; i = i - 1)
        begin
            if (g1_pend[i])
            begin
                found = 1'b1;
                pick_src = {1'b0, i[2:0]};
            end
        end
        if (!found)
        begin
            for (i = G2_W - 1; i >= 0; i = i - 1)
            begin
                if (g2_pend[i])
                begin
                    found = 1'b1;
                    pick_src = {1'b1, i[2:0]};
                end
            end
        end
    end

    // vector request held until acknowledged
    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            vec_req_q <= 1'b0;
            vec_src_q <= 4'h0;
            vec_level_q <= `IRQPR_LVL_OFF;
        end
        else if (vec_req_q)
        begin
            if (vec_ack)
                vec_req_q <= 1'b0;
        end
        // only while globally enabled; else pending bits stay for polling
        else if (global_interrupt_enable && vec_en_q && found)
        begin
            vec_req_q <= 1'b1;
            vec_src_q <= pick_src;
            vec_level_q <= `IRQPR_LVL_1;
        end
    end

    // sticky status, write one to clear, set wins
    always @*
    begin
        stat_d = stat_q;
        if (wr_en && widx == `IRQPR_IDX_IRQ_STAT)
            stat_d = stat_q & ~pwdata[`IRQPR_ST_W-1:0];
        if (|porta_req)
            stat_d[`IRQPR_ST_G1] = 1'b1;
        if (|portc_req)
            stat_d[`IRQPR_ST_G2] = 1'b1;
        if (vec_ack && vec_req_q)
            stat_d[`IRQPR_ST_VEC] = 1'b1;
    end

    always @(posedge clk_sys)
    begin
        if (!rst_b)
            stat_q <= {`IRQPR_ST_W{1'b0}};
        else
            stat_q <= stat_d;
    end

    assign irq_out = |(stat_q & mask_q);

    always @*
    begin
        case (widx)
            `IRQPR_IDX_G0_EN_HI: rd_mux = {24'h00_0000, group0_enable_high_q};
            `IRQPR_IDX_G0_EN_LO: rd_mux = {24'h00_0000, group0_enable_low_q};
            `IRQPR_IDX_G1_PEND: rd_mux = {{(32-G1_W){1'b0}}, g1_pend};
            `IRQPR_IDX_G2_PEND: rd_mux = {{(32-G2_W){1'b0}}, g2_pend};
            `IRQPR_IDX_IRQ_STAT: rd_mux = {{(32-`IRQPR_ST_W){1'b0}}, stat_q};
            `IRQPR_IDX_IRQ_MASK: rd_mux = {{(32-`IRQPR_ST_W){1'b0}}, mask_q};
            `IRQPR_IDX_CTRL: rd_mux = {31'h0000_0000, vec_en_q};
            `IRQPR_IDX_VECT: rd_mux = {24'h00_0000, vec_req_q, 1'b0, vec_level_q, vec_src_q};
            default: rd_mux = `IRQPR_RST_WORD;
        endcase
    end

    // read data registered at setup so it is valid in the access cycle
    always @(posedge clk_sys)
    begin
        if (!rst_b)
            prdata <= `IRQPR_RST_WORD;
        else if (psel && !penable && !pwrite)
            prdata <= rd_mux;
    end

    wire unused_rd;
    assign unused_rd = rd_en;
endmodule
`default_nettype wire

// ---- rtl/irqpr_defines.vh ----
// irqpr_defines.vh: register map, field positions and reset values of the
// interrupt request and priority register block.
// assumes inclusion by bare name from the rtl files.
`ifndef IRQPR_DEFINES_VH
`define IRQPR_DEFINES_VH

// printed offsets are register indices; byte address is four times the index
`define IRQPR_IDX_G0_EN_HI 12'h0fc1
`define IRQPR_IDX_G0_EN_LO 12'h0fc2
`define IRQPR_IDX_G1_PEND 12'h0fc3
`define IRQPR_IDX_G2_PEND 12'h0fc6
`define IRQPR_IDX_IRQ_STAT 12'h0fd0
`define IRQPR_IDX_IRQ_MASK 12'h0fd1
`define IRQPR_IDX_CTRL 12'h0fd2
`define IRQPR_IDX_VECT 12'h0fd3

// writable bits of the group-0 enable pair
`define IRQPR_G0_EN_WMASK 8'h79
// group-2 pending bits that exist
`define IRQPR_G2_PEND_WMASK 8'h0f
`define IRQPR_RST_BYTE 8'h00
`define IRQPR_RST_WORD 32'h0000_0000

// group-0 enable field positions
`define IRQPR_BIT_TIMER1 3'd6
`define IRQPR_BIT_TIMER0 3'd5
`define IRQPR_BIT_SERIAL_RX 3'd4
`define IRQPR_BIT_SERIAL_TX 3'd3
`define IRQPR_BIT_CONVERTER 3'd0

// priority levels of an enable pair
`define IRQPR_LVL_OFF 2'd0
`define IRQPR_LVL_1 2'd1
`define IRQPR_LVL_2 2'd2
`define IRQPR_LVL_3 2'd3

// interrupt status bits
`define IRQPR_ST_G1 0
`define IRQPR_ST_G2 1
`define IRQPR_ST_VEC 2
`define IRQPR_ST_W 3

`endif

// ---- rtl/irqpr_pend_bit.v ----
// irqpr_pend_bit.v: one pending-request flag with hardware set, software
// write and cpu acknowledge.
// assumes request and ack are single-cycle pulses on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module irqpr_pend_bit
(
    input wire clk_sys,
    input wire rst_b,
    input wire hw_set,
    input wire sw_wr,
    input wire sw_val,
    input wire ack,
    output reg pend_q
);
    reg pend_d;

    always @*
    begin
        pend_d = pend_q;
        if (ack)
            pend_d = 1'b0;
        if (sw_wr)
            pend_d = sw_val;
        // hardware request beats clear and ack so nothing is lost
        if (hw_set)
            pend_d = 1'b1;
    end

    always @(posedge clk_sys)
    begin
        if (!rst_b)
            pend_q <= 1'b0;
        else
            pend_q <= pend_d;
    end
endmodule
`default_nettype wire

// ---- tb/irqpr_regs_props.sv ----
// irqpr_regs_props.sv: port assertions for irqpr_regs.
// assumes clk_sys only and rst_b synchronous active low.
`timescale 1ns/1ps
`default_nettype none
`include "irqpr_defines.vh"
module irqpr_props
(
    input wire clk_sys,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [15:0] paddr,
    input wire [31:0] pwdata,
    input wire global_interrupt_enable,
    input wire vec_ack,
    input wire vec_req_q,
    input wire [3:0] vec_src_q,
    input wire [1:0] vec_level_q,
    input wire [7:0] group0_level_timer1
);
    wire wr_acc = psel && penable && pwrite;
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    a_vec_level: assert property (vec_req_q |-> vec_level_q == 2'h1)
        else $error("vector level not one");
    a_vec_hold: assert property (vec_req_q && !vec_ack |=> vec_req_q && $stable(vec_src_q))
        else $error("vector dropped before ack");
    a_ack_drop: assert property (vec_req_q && vec_ack |=> !vec_req_q)
        else $error("vector kept after ack");
    a_polled_quiet: assert property (!global_interrupt_enable && !vec_req_q |=> !vec_req_q)
        else $error("vector while globally off");
    a_g2_pin: assert property (vec_req_q && vec_src_q[3] |-> !vec_src_q[2])
        else $error("group2 pin out of range");
    a_t1_high: assert property (wr_acc && paddr == {2'h0, `IRQPR_IDX_G0_EN_HI, 2'h0}
        |=> group0_level_timer1[1] == $past(pwdata[6])) else $error("timer1 high bit wrong");
    a_t1_low: assert property (wr_acc && paddr == {2'h0, `IRQPR_IDX_G0_EN_LO, 2'h0}
        |=> group0_level_timer1[0] == $past(pwdata[6])) else $error("timer1 low bit wrong");
    a_t1_pair: assert property (group0_level_timer1[7:2] == 6'h00)
        else $error("timer1 level upper bits set");
    a_lvl_hold: assert property (!wr_acc |=> $stable(group0_level_timer1))
        else $error("timer1 level changed without a write");
endmodule
bind irqpr_regs irqpr_props u_props (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .global_interrupt_enable(global_interrupt_enable), .vec_ack(vec_ack),
    .vec_req_q(vec_req_q), .vec_src_q(vec_src_q), .vec_level_q(vec_level_q),
    .group0_level_timer1(group0_level_timer1));
`default_nettype wire

// ---- tb/irqpr_cpu_model.sv ----
// irqpr_cpu_model.sv: cpu core taking vectored requests.
// acks ack_wait+1 cycles after a request with a one-cycle pulse.
`timescale 1ns/1ps
`default_nettype none
module irqpr_cpu_model
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic vec_req_q,
    input wire logic [3:0] vec_src_q,
    input wire logic [7:0] ack_wait,
    output logic vec_ack,
    output logic [3:0] taken_src,
    output logic [7:0] taken_n
);
    logic [7:0] cnt_q;
    always @(posedge clk_sys)
    begin
        if (!rst_b)
        begin
            vec_ack <= 1'b0;
            cnt_q <= 8'h00;
            taken_n <= 8'h00;
        end
        else if (vec_ack)
        begin
            vec_ack <= 1'b0;
            cnt_q <= 8'h00;
            taken_n <= taken_n + 8'h01;
            taken_src <= vec_src_q;
        end
        else if (vec_req_q && cnt_q >= ack_wait)
            vec_ack <= 1'b1;
        else if (vec_req_q)
            cnt_q <= cnt_q + 8'h01;
    end
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
// tb.sv: self-checking bench for irqpr_regs with a cpu model.
// assumes one-cycle request pulses; the apb master waits for pready.
`timescale 1ns/1ps
`default_nettype none
`include "irqpr_defines.vh"
module tb;
    logic clk_sys = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, gie = 0, err;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, prdata;
    logic [7:0] porta_req = 0, ack_wait = 0, lvl, taken_n;
    logic [3:0] portc_req = 0, taken_src, vec_src_q;
    logic pready, pslverr, vec_req_q, vec_ack, irq_out;
    logic [1:0] vec_level_q;
    int n_mismatch = 0, check_count = 0, i;
    initial forever #10 clk_sys = ~clk_sys;
    irqpr_regs DUT (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .porta_req(porta_req), .portc_req(portc_req),
        .global_interrupt_enable(gie), .vec_ack(vec_ack), .vec_req_q(vec_req_q),
        .vec_src_q(vec_src_q), .vec_level_q(vec_level_q), .group0_level_timer1(lvl),
        .irq_out(irq_out));
    irqpr_cpu_model u_cpu (.clk_sys(clk_sys), .rst_b(rst_b), .vec_req_q(vec_req_q),
        .vec_src_q(vec_src_q), .ack_wait(ack_wait), .vec_ack(vec_ack),
        .taken_src(taken_src), .taken_n(taken_n));
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task report_and_stop;
        $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task apb(input logic w, input [11:0] idx, input [7:0] d);
        int k;
        @(posedge clk_sys);
        psel <= 1;
        pwrite <= w;
        paddr <= {2'h0, idx, 2'h0};
        pwdata <= {24'h00_0000, d};
        @(posedge clk_sys);
        penable <= 1;
        k = 0;
        do
        begin
            @(posedge clk_sys);
            k++;
        end
        while (!pready && k < 16);
        if (!pready)
        begin
            n_mismatch++;
            report_and_stop;
        end
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
        @(negedge clk_sys);
    endtask
    task rdchk(input [11:0] idx, input [7:0] exp);
        apb(0, idx, 8'h00);
        chk(rd, {24'h00_0000, exp});
    endtask
    task pulse(input [7:0] a, input [3:0] c);
        @(posedge clk_sys);
        porta_req <= a;
        portc_req <= c;
        @(posedge clk_sys);
        porta_req <= 0;
        portc_req <= 0;
        @(negedge clk_sys);
    endtask
    task wait_taken(input [7:0] n, input [3:0] src);
        int k;
        for (k = 0; k < 40 && taken_n !== n; k++)
            @(posedge clk_sys);
        if (taken_n !== n)
        begin
            n_mismatch++;
            report_and_stop;
        end
        chk(taken_src, src);
    endtask
    task t_regs;
        rdchk(`IRQPR_IDX_G1_PEND, 8'h00);
        apb(0, 12'h0fe0, 8'h00);
        chk({31'h0000_0000, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        apb(1, `IRQPR_IDX_G0_EN_HI, 8'hff);
        rdchk(`IRQPR_IDX_G0_EN_HI, 8'h79);
        apb(1, `IRQPR_IDX_G0_EN_LO, 8'hff);
        rdchk(`IRQPR_IDX_G0_EN_LO, 8'h79);
        for (i = 0; i < 4; i++)
        begin
            apb(1, `IRQPR_IDX_G0_EN_HI, {1'b0, i[1], 6'h00});
            apb(1, `IRQPR_IDX_G0_EN_LO, {1'b0, i[0], 6'h00});
            chk(lvl, i);
        end
        $display("test regs done");
    endtask
    task t_pend;
        for (i = 0; i < 8; i++)
        begin
            pulse(8'h01 << i, 4'h0);
            rdchk(`IRQPR_IDX_G1_PEND, 8'h01 << i);
            apb(1, `IRQPR_IDX_G1_PEND, 8'h00);
        end
        for (i = 0; i < 4; i++)
        begin
            pulse(8'h00, 4'h1 << i);
            rdchk(`IRQPR_IDX_G2_PEND, 8'h01 << i);
            apb(1, `IRQPR_IDX_G2_PEND, 8'h00);
        end
        apb(1, `IRQPR_IDX_G2_PEND, 8'hff);
        rdchk(`IRQPR_IDX_G2_PEND, 8'h0f);
        fork
            apb(1, `IRQPR_IDX_G2_PEND, 8'h00);
            begin
                @(posedge clk_sys);
                pulse(8'h00, 4'h2);
            end
        join
        rdchk(`IRQPR_IDX_G2_PEND, 8'h02);
        apb(1, `IRQPR_IDX_G2_PEND, 8'h00);
        $display("test pend done");
    endtask
    task t_vec;
        apb(1, `IRQPR_IDX_CTRL, 8'h01);
        rdchk(`IRQPR_IDX_CTRL, 8'h01);
        @(posedge clk_sys);
        gie <= 1;
        ack_wait <= 8'h03;
        pulse(8'h00, 4'h4);
        wait_taken(8'h01, 4'ha);
        rdchk(`IRQPR_IDX_G2_PEND, 8'h00);
        @(posedge clk_sys);
        ack_wait <= 8'h00;
        apb(1, `IRQPR_IDX_G1_PEND, 8'h80);
        wait_taken(8'h02, 4'h7);
        @(posedge clk_sys);
        gie <= 0;
        pulse(8'h01, 4'h0);
        repeat (4) @(posedge clk_sys);
        chk(vec_req_q, 1'b0);
        rdchk(`IRQPR_IDX_G1_PEND, 8'h01);
        rdchk(`IRQPR_IDX_VECT, 8'h17);
        apb(1, `IRQPR_IDX_IRQ_MASK, 8'h01);
        rdchk(`IRQPR_IDX_IRQ_MASK, 8'h01);
        chk(irq_out, 1'b1);
        apb(1, `IRQPR_IDX_G1_PEND, 8'h00);
        apb(1, `IRQPR_IDX_IRQ_STAT, 8'h07);
        chk(irq_out, 1'b0);
        $display("test vec done");
    endtask
    task t_reset;
        apb(1, `IRQPR_IDX_G0_EN_LO, 8'h41);
        pulse(8'h20, 4'h8);
        chk(lvl, 8'h03);
        chk(irq_out, 1'b1);
        rdchk(`IRQPR_IDX_G2_PEND, 8'h08);
        @(posedge clk_sys);
        rst_b <= 0;
        repeat (2) @(posedge clk_sys);
        rst_b <= 1;
        chk(lvl, 8'h00);
        chk(irq_out, 1'b0);
        rdchk(`IRQPR_IDX_G1_PEND, 8'h00);
        rdchk(`IRQPR_IDX_G2_PEND, 8'h00);
        rdchk(`IRQPR_IDX_G0_EN_LO, 8'h00);
        $display("test reset done");
    endtask
    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst_b <= 1;
        t_regs;
        t_pend;
        t_vec;
        t_reset;
        report_and_stop;
    end
endmodule
`default_nettype wire
